// ### cspd_pkg.sv
package cspd_pkg;

    // output counts
    localparam int NUM_CPU  = 3;
    localparam int NUM_PCI  = 6;
    localparam int NUM_FREE = 2;
    localparam int NUM_EXP  = 8;

    // register bus
    localparam int         ADDR_W      = 4;
    localparam int         DATA_W      = 8;
    localparam logic [3:0] REG_CTRL0   = 4'h0;
    localparam logic [3:0] REG_EXP_EN  = 4'h3;
    localparam logic [3:0] REG_CPU_EN  = 4'h4;
    localparam logic [3:0] REG_DRIVE   = 4'h5;
    localparam logic [3:0] REG_STATUS  = 4'h8;

    // reset values and writable masks
    localparam logic [7:0] CTRL0_RST   = 8'h08;
    localparam logic [7:0] CTRL0_MASK  = 8'h08;
    localparam logic [7:0] EXP_EN_RST  = 8'h00;
    localparam logic [7:0] CPU_EN_RST  = 8'h07;
    localparam logic [7:0] CPU_EN_MASK = 8'h1F;
    localparam logic [7:0] DRIVE_RST   = 8'h00;

    // field positions
    localparam int SW_PCI_RUN_BIT   = 3;
    localparam int CPU_EN_LSB       = 0;
    localparam int FREE_EN_LSB      = 3;
    localparam int CPU_PD_HIZ_LSB   = 0;
    localparam int EXP_PD_HIZ_BIT   = 3;
    localparam int CPU_STOP_HIZ_LSB = 4;
    localparam int EXP_STOP_HIZ_BIT = 7;
    localparam int ST_DOWN_BIT      = 0;
    localparam int ST_RUN_BIT       = 1;
    localparam int ST_CPU_HALT_BIT  = 2;
    localparam int ST_PCI_HALT_BIT  = 3;

    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int LOCK_TIME_US  = 1800;
    localparam int LOCK_CYC_DEF  = LOCK_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int LOCK_CNT_W    = 18;
    localparam logic [1:0] PCI_DIV_LAST = 2'h2;

    typedef enum logic [4:0] {
        ST_PGOOD = 5'b00001,
        ST_LOCK  = 5'b00010,
        ST_RUN   = 5'b00100,
        ST_ENTRY = 5'b01000,
        ST_DOWN  = 5'b10000
    } cspd_state_e;

    // one differential pair: level and enable of each leg, drive level
    typedef struct packed {
        logic true_v;
        logic true_oe;
        logic comp_v;
        logic comp_oe;
        logic drive_full;
    } cspd_diff_s;

endpackage : cspd_pkg

// ### cspd_ctrl.sv
// Our own choices: strobed register access and the address map.
`timescale 1ns/100ps
// Behaviour
// - shared pin is power-good, then power-down
// - power-down asynchronous, synchronised before acting
// - single-ended low after two complement samples
// - differential pairs park within four periods
// - drive mode 0: true high, complement tri-state
// - drive mode 1: both legs tri-state
// - stable clocks within lock time after release
// - tri-stated pairs driven high after release
// - all outputs enabled together after lock
// - cpu halt stops enabled outputs after sampling
// - stopped cpu: true high, full drive
// - cpu resume synchronous, within two cycles
// - pci halt stops pci, free outputs selectable
// - pci resume synchronous within two periods
// - pin and register bit combined, rest low
// - register bit reads 0 when halted
// - per cpu output halt enable bit
// - stop drive mode: driven or tri-state
module cspd_ctrl #(
    parameter int LOCK_CYC = cspd_pkg::LOCK_CYC_DEF
) (
    input  wire logic                                    CLK_SYS_I,
    input  wire logic                                    SYS_RST_I,
    input  wire logic                                    POWER_GOOD_N_OR_DOWN_I,
    input  wire logic                                    CPU_HALT_N_I,
    input  wire logic                                    PCI_HALT_N_I,
    input  wire logic [cspd_pkg::ADDR_W-1:0]             REG_ADDR_I,
    input  wire logic [cspd_pkg::DATA_W-1:0]             REG_WDATA_I,
    input  wire logic                                    REG_WR_I,
    input  wire logic                                    REG_RD_I,
    output logic      [cspd_pkg::DATA_W-1:0]             REG_RDATA_O,
    output cspd_pkg::cspd_diff_s [cspd_pkg::NUM_CPU-1:0] CPU_CLOCK_O,
    output cspd_pkg::cspd_diff_s [cspd_pkg::NUM_EXP-1:0] EXPRESS_REF_CLOCK_O,
    output logic      [cspd_pkg::NUM_PCI-1:0]            PCI_CLOCK_O,
    output logic      [cspd_pkg::NUM_FREE-1:0]           FREE_PCI_CLOCK_O
);

    function automatic cspd_pkg::cspd_diff_s diff_drive(
        input logic ph,
        input logic parked,
        input logic hiz,
        input logic full
    );
        cspd_pkg::cspd_diff_s d;
        d.true_v     = parked | ph;
        d.true_oe    = ~(parked & hiz);
        d.comp_v     = ~parked & ~ph;
        d.comp_oe    = ~parked;
        d.drive_full = full;
        return d;
    endfunction : diff_drive

    cspd_pkg::cspd_state_e state;
    cspd_pkg::cspd_state_e next_state;

    logic [2:0]                        sync_meta;
    logic [2:0]                        sync_q;
    logic                              pin_sync;
    logic                              cpu_halt_n_sync;
    logic                              pci_halt_n_sync;
    logic [1:0]                        pd_smp;
    logic [1:0]                        halt_smp;
    logic                              cpu_ph;
    logic [1:0]                        pci_cnt;
    logic [1:0]                        next_pci_cnt;
    logic                              cpu_rise_evt;
    logic                              cpu_fall_evt;
    logic                              pci_fall_evt;
    logic [cspd_pkg::LOCK_CNT_W-1:0]   lock_cnt;
    logic                              lock_done;
    logic                              diff_park;
    logic                              se_park;
    logic [cspd_pkg::NUM_CPU-1:0]      cpu_stop;
    logic [cspd_pkg::NUM_EXP-1:0]      exp_stop;
    logic                              pci_stop;
    logic [cspd_pkg::NUM_FREE-1:0]     free_stop;
    logic [7:0]                        ctrl0;
    logic [7:0]                        exp_en;
    logic [7:0]                        cpu_en;
    logic [7:0]                        drive;
    logic                              pci_run;
    logic                              pd_view;
    logic [7:0]                        next_rdata;

    cspd_pkg::cspd_diff_s [cspd_pkg::NUM_CPU-1:0] next_cpu;
    cspd_pkg::cspd_diff_s [cspd_pkg::NUM_EXP-1:0] next_exp;
    logic [cspd_pkg::NUM_PCI-1:0]                 next_pci;
    logic [cspd_pkg::NUM_FREE-1:0]                next_free;

    // async inputs: meta stage feeds only the second stage
    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            sync_meta <= 3'h7; // idle pins: supply not good, no halt
            sync_q    <= 3'h7;
        end else begin
            sync_meta <= {PCI_HALT_N_I, CPU_HALT_N_I, POWER_GOOD_N_OR_DOWN_I};
            sync_q    <= sync_meta;
        end
    end

    assign pin_sync        = sync_q[0];
    assign cpu_halt_n_sync = sync_q[1];
    assign pci_halt_n_sync = sync_q[2];

    // internal clock phases: cpu pair toggles each cycle, pci divides by three
    assign cpu_rise_evt = cpu_ph;          // complement rises on next edge
    assign cpu_fall_evt = ~cpu_ph;         // complement falls, true rises
    assign pci_fall_evt = (pci_cnt == 2'h0);
    assign next_pci_cnt = (pci_cnt == cspd_pkg::PCI_DIV_LAST) ? 2'h0 : pci_cnt + 2'h1;

    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            cpu_ph  <= 1'b0;
            pci_cnt <= 2'h0;
        end else begin
            cpu_ph  <= ~cpu_ph;
            pci_cnt <= next_pci_cnt;
        end
    end

    // samples taken on complement rising edges
    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            pd_smp   <= 2'h0;
            halt_smp <= 2'h0;
        end else if (cpu_rise_evt) begin
            pd_smp   <= {pd_smp[0], pin_sync};
            halt_smp <= {halt_smp[0], ~cpu_halt_n_sync};
        end
    end

    assign lock_done = (lock_cnt == cspd_pkg::LOCK_CNT_W'(LOCK_CYC - 1));

    always_comb begin
        next_state = state;
        case (state)
            cspd_pkg::ST_PGOOD: begin
                if (!pin_sync) begin
                    next_state = cspd_pkg::ST_LOCK;
                end
            end
            cspd_pkg::ST_LOCK: begin
                if (pin_sync) begin
                    next_state = cspd_pkg::ST_DOWN;
                end else if (lock_done) begin
                    next_state = cspd_pkg::ST_RUN;
                end
            end
            cspd_pkg::ST_RUN: begin
                if (&pd_smp) begin
                    next_state = cspd_pkg::ST_ENTRY;
                end
            end
            cspd_pkg::ST_ENTRY: begin
                if (diff_park && se_park) begin
                    next_state = cspd_pkg::ST_DOWN;
                end
            end
            cspd_pkg::ST_DOWN: begin
                if (!pin_sync) begin
                    next_state = cspd_pkg::ST_LOCK;
                end
            end
            default: next_state = cspd_pkg::ST_PGOOD;
        endcase
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            state <= cspd_pkg::ST_PGOOD;
        end else begin
            state <= next_state;
        end
    end

    // pll settle time; restarts on every entry
    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I || state != cspd_pkg::ST_LOCK) begin
            lock_cnt <= '0;
        end else if (!lock_done) begin
            lock_cnt <= lock_cnt + 1'b1;
        end
    end

    // parking happens only on the edge that keeps the waveform whole
    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I || state != cspd_pkg::ST_ENTRY) begin
            diff_park <= 1'b0;
            se_park   <= 1'b0;
        end else begin
            if (cpu_fall_evt) begin
                diff_park <= 1'b1;
            end
            if (pci_fall_evt) begin
                se_park <= 1'b1;
            end
        end
    end

    assign pci_run = pci_halt_n_sync & ctrl0[cspd_pkg::SW_PCI_RUN_BIT];

    // stop state changes only while the true leg is about to rise
    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            cpu_stop <= '0;
            exp_stop <= '0;
        end else if (cpu_fall_evt) begin
            cpu_stop <= {cspd_pkg::NUM_CPU{halt_smp[1]}}
                        & cpu_en[cspd_pkg::CPU_EN_LSB +: cspd_pkg::NUM_CPU];
            exp_stop <= {cspd_pkg::NUM_EXP{~pci_run}} & exp_en;
        end
    end

    // single-ended stop changes only while the output falls
    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            pci_stop  <= 1'b0;
            free_stop <= '0;
        end else if (pci_fall_evt) begin
            pci_stop  <= ~pci_run;
            free_stop <= {cspd_pkg::NUM_FREE{~pci_run}}
                         & cpu_en[cspd_pkg::FREE_EN_LSB +: cspd_pkg::NUM_FREE];
        end
    end

    assign pd_view = (state == cspd_pkg::ST_DOWN)
                     || (state == cspd_pkg::ST_ENTRY && diff_park);

    always_comb begin
        for (int i = 0; i < cspd_pkg::NUM_CPU; i++) begin
            if (state == cspd_pkg::ST_PGOOD) begin
                next_cpu[i] = diff_drive(~cpu_ph, 1'b1, 1'b1, 1'b0);
            end else if (state == cspd_pkg::ST_LOCK) begin
                next_cpu[i] = diff_drive(~cpu_ph, 1'b1, 1'b0, 1'b0);
            end else if (pd_view) begin
                next_cpu[i] = diff_drive(~cpu_ph, 1'b1,
                                         drive[cspd_pkg::CPU_PD_HIZ_LSB + i], 1'b0);
            end else begin
                next_cpu[i] = diff_drive(~cpu_ph, cpu_stop[i],
                                         drive[cspd_pkg::CPU_STOP_HIZ_LSB + i], 1'b1);
            end
        end
        for (int k = 0; k < cspd_pkg::NUM_EXP; k++) begin
            if (state == cspd_pkg::ST_PGOOD) begin
                next_exp[k] = diff_drive(~cpu_ph, 1'b1, 1'b1, 1'b0);
            end else if (state == cspd_pkg::ST_LOCK) begin
                next_exp[k] = diff_drive(~cpu_ph, 1'b1, 1'b0, 1'b0);
            end else if (pd_view) begin
                next_exp[k] = diff_drive(~cpu_ph, 1'b1,
                                         drive[cspd_pkg::EXP_PD_HIZ_BIT], 1'b0);
            end else begin
                next_exp[k] = diff_drive(~cpu_ph, exp_stop[k],
                                         drive[cspd_pkg::EXP_STOP_HIZ_BIT], 1'b1);
            end
        end
    end

    always_comb begin
        if (state == cspd_pkg::ST_RUN || (state == cspd_pkg::ST_ENTRY && !se_park)) begin
            next_pci  = {cspd_pkg::NUM_PCI{(next_pci_cnt == 2'h0) & ~pci_stop}};
            next_free = {cspd_pkg::NUM_FREE{next_pci_cnt == 2'h0}} & ~free_stop;
        end else begin
            next_pci  = '0;
            next_free = '0;
        end
    end

    // all outputs leave the same flops, so they enable on one edge
    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            CPU_CLOCK_O         <= '0;
            EXPRESS_REF_CLOCK_O <= '0;
            PCI_CLOCK_O         <= '0;
            FREE_PCI_CLOCK_O    <= '0;
        end else begin
            CPU_CLOCK_O         <= next_cpu;
            EXPRESS_REF_CLOCK_O <= next_exp;
            PCI_CLOCK_O         <= next_pci;
            FREE_PCI_CLOCK_O    <= next_free;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            ctrl0  <= cspd_pkg::CTRL0_RST;
            exp_en <= cspd_pkg::EXP_EN_RST;
            cpu_en <= cspd_pkg::CPU_EN_RST;
            drive  <= cspd_pkg::DRIVE_RST;
        end else if (REG_WR_I) begin
            case (REG_ADDR_I)
                cspd_pkg::REG_CTRL0:  ctrl0  <= REG_WDATA_I & cspd_pkg::CTRL0_MASK;
                cspd_pkg::REG_EXP_EN: exp_en <= REG_WDATA_I;
                cspd_pkg::REG_CPU_EN: cpu_en <= REG_WDATA_I & cspd_pkg::CPU_EN_MASK;
                cspd_pkg::REG_DRIVE:  drive  <= REG_WDATA_I;
                default: ;
            endcase
        end
    end

    always_comb begin
        next_rdata = 8'h00;
        case (REG_ADDR_I)
            cspd_pkg::REG_CTRL0: begin
                next_rdata[cspd_pkg::SW_PCI_RUN_BIT] = pci_run;
            end
            cspd_pkg::REG_EXP_EN: next_rdata = exp_en;
            cspd_pkg::REG_CPU_EN: next_rdata = cpu_en;
            cspd_pkg::REG_DRIVE:  next_rdata = drive;
            cspd_pkg::REG_STATUS: begin
                next_rdata[cspd_pkg::ST_DOWN_BIT]     = (state == cspd_pkg::ST_DOWN);
                next_rdata[cspd_pkg::ST_RUN_BIT]      = (state == cspd_pkg::ST_RUN);
                next_rdata[cspd_pkg::ST_CPU_HALT_BIT] = halt_smp[1];
                next_rdata[cspd_pkg::ST_PCI_HALT_BIT] = pci_stop;
            end
            default: next_rdata = 8'h00;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            REG_RDATA_O <= 8'h00;
        end else if (REG_RD_I) begin
            REG_RDATA_O <= next_rdata;
        end else begin
            REG_RDATA_O <= 8'h00;
        end
    end

endmodule : cspd_ctrl

// ### cspd_chk.sv
`timescale 1ns/100ps
module cspd_chk (
    input wire logic                       CLK_SYS_I,
    input wire logic                       SYS_RST_I,
    input wire logic                       POWER_GOOD_N_OR_DOWN_I,
    input wire logic                       PCI_HALT_N_I,
    input wire logic [3:0]                 REG_ADDR_I,
    input wire logic                       REG_RD_I,
    input wire logic [7:0]                 REG_RDATA_O,
    input wire cspd_pkg::cspd_diff_s [2:0] CPU_CLOCK_O,
    input wire logic [5:0]                 PCI_CLOCK_O,
    input wire logic [1:0]                 FREE_PCI_CLOCK_O
);
    logic                 any_comp;
    cspd_pkg::cspd_diff_s p0;
    assign any_comp = CPU_CLOCK_O[0].comp_oe | CPU_CLOCK_O[1].comp_oe | CPU_CLOCK_O[2].comp_oe;
    assign p0 = CPU_CLOCK_O[0];
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (SYS_RST_I);
    // margin covers sync, two complement samples and the slow pci phase
    sequence pd_held;
        POWER_GOOD_N_OR_DOWN_I [*8];
    endsequence
    rd_idle_a: assert property (!REG_RD_I |=> REG_RDATA_O == 8'h00)
        else $error("read data not zero outside a read");
    rd_unmapped_a: assert property (REG_RD_I && REG_ADDR_I == 4'h1 |=> REG_RDATA_O == 8'h00)
        else $error("unmapped read not zero");
    pci_read_a: assert property ((!PCI_HALT_N_I) [*4] ##0
        (REG_RD_I && REG_ADDR_I == cspd_pkg::REG_CTRL0) |=> !REG_RDATA_O[3])
        else $error("run bit reads 1 while pin stops pci");
    pci_halt_low_a: assert property ((!PCI_HALT_N_I) [*8] |-> ##1 PCI_CLOCK_O == 6'h00)
        else $error("pci clocks not held low");
    pd_se_low_a: assert property (pd_held |-> ##6 PCI_CLOCK_O == 6'h00
        && FREE_PCI_CLOCK_O == 2'h0)
        else $error("single-ended clocks not low in power-down");
    pd_park_a: assert property (pd_held |-> ##6 !any_comp)
        else $error("pairs not parked in power-down");
    pd_drive_a: assert property (pd_held |-> ##6 !p0.drive_full)
        else $error("power-down pair not at low drive");
    park_true_a: assert property (p0.true_oe && !p0.comp_oe |-> p0.true_v)
        else $error("parked pair true leg not high");
    cover property ((!PCI_HALT_N_I) [*8]);
    cover property (pd_held ##1 !POWER_GOOD_N_OR_DOWN_I);
    cover property (p0.true_oe && !p0.comp_oe && p0.drive_full);
endmodule : cspd_chk

bind cspd_ctrl cspd_chk u_chk (
    .CLK_SYS_I(CLK_SYS_I), .SYS_RST_I(SYS_RST_I),
    .POWER_GOOD_N_OR_DOWN_I(POWER_GOOD_N_OR_DOWN_I), .PCI_HALT_N_I(PCI_HALT_N_I),
    .REG_ADDR_I(REG_ADDR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
    .CPU_CLOCK_O(CPU_CLOCK_O), .PCI_CLOCK_O(PCI_CLOCK_O),
    .FREE_PCI_CLOCK_O(FREE_PCI_CLOCK_O)
);

// ### cspd_pm_model.sv
`timescale 1ns/100ps
module cspd_pm_model (
    input  wire logic CLK_SYS_I,
    output logic      pin_o,
    output logic      cpu_halt_n_o,
    output logic      pci_halt_n_o
);
    // shared pin high at start reads as supply not yet good
    initial begin
        pin_o        = 1'b1;
        cpu_halt_n_o = 1'b1;
        pci_halt_n_o = 1'b1;
    end
    task automatic set_pins(input logic pd, input logic cpu_n, input logic pci_n);
        @(posedge CLK_SYS_I);
        pin_o        <= pd;
        cpu_halt_n_o <= cpu_n;
        pci_halt_n_o <= pci_n;
    endtask : set_pins
    // five cycles sits far inside the allowed delay
    task automatic start_down();
        set_pins(1'b0, 1'b1, 1'b1);
        repeat (5) @(posedge CLK_SYS_I);
        pin_o <= 1'b1;
    endtask : start_down
endmodule : cspd_pm_model

// ### cspd_ctrl_tb.sv
`timescale 1ns/100ps
module cspd_ctrl_tb;
    localparam int LOCK = 20;
    logic                       clk, rst, wr, rd;
    logic [3:0]                 addr;
    logic [7:0]                 wdata, rdata;
    wire                        pin, cpu_n, pci_n;
    cspd_pkg::cspd_diff_s [2:0] cpu;
    cspd_pkg::cspd_diff_s [7:0] exr;
    logic [5:0]                 pci;
    logic [1:0]                 fr;
    int                         failures, n_checks;

    cspd_pm_model u_pm (.CLK_SYS_I(clk), .pin_o(pin), .cpu_halt_n_o(cpu_n), .pci_halt_n_o(pci_n));
    cspd_ctrl #(.LOCK_CYC(LOCK)) u_dut (
        .CLK_SYS_I(clk), .SYS_RST_I(rst), .POWER_GOOD_N_OR_DOWN_I(pin),
        .CPU_HALT_N_I(cpu_n), .PCI_HALT_N_I(pci_n), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
        .CPU_CLOCK_O(cpu), .EXPRESS_REF_CLOCK_O(exr), .PCI_CLOCK_O(pci),
        .FREE_PCI_CLOCK_O(fr)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic wrap_up();
        if (failures == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        n_checks = n_checks + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e,
                          input string what);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(what, e, rdata & m);
    endtask : rd_chk

    // undriven legs are masked: their level carries no meaning
    function automatic logic [7:0] pk(input cspd_pkg::cspd_diff_s p);
        return {4'h0, p.true_v & p.true_oe, p.true_oe, p.comp_oe, p.drive_full & p.true_oe};
    endfunction : pk

    task automatic run_chk(input logic [7:0] pe, input logic [7:0] fe, input logic [7:0] se);
        logic [5:0] pa;
        logic [1:0] fa;
        logic       tv;
        logic       stuck;
        pa    = 6'h00;
        fa    = 2'h0;
        stuck = 1'b0;
        tv    = cpu[1].true_v;
        repeat (6) begin
            cyc(1);
            pa    = pa | pci;
            fa    = fa | fr;
            stuck = stuck | (cpu[1].true_v === tv);
            tv    = cpu[1].true_v;
        end
        chk("pci clocks", pe, {2'h0, pa});
        chk("free clocks", fe, {6'h00, fa});
        chk("cpu stuck", se, {7'h00, stuck});
    endtask : run_chk

    task automatic t_powerup();
        rd_chk(cspd_pkg::REG_STATUS, 8'h03, 8'h00, "wait good");
        rd_chk(cspd_pkg::REG_CPU_EN, 8'hFF, 8'h07, "cpu enables");
        rd_chk(4'h1, 8'hFF, 8'h00, "unmapped");
        u_pm.start_down();
        cyc(8);
        rd_chk(cspd_pkg::REG_STATUS, 8'h03, 8'h01, "held down");
        u_pm.set_pins(1'b0, 1'b1, 1'b1);
        cyc(LOCK - 6);
        rd_chk(cspd_pkg::REG_STATUS, 8'h03, 8'h00, "locking");
        cyc(12);
        rd_chk(cspd_pkg::REG_STATUS, 8'h03, 8'h02, "running");
        run_chk(8'h3F, 8'h03, 8'h00);
    endtask : t_powerup

    task automatic t_cpu();
        wr_reg(cspd_pkg::REG_CPU_EN, 8'hE3);
        rd_chk(cspd_pkg::REG_CPU_EN, 8'hFF, 8'h03, "enable mask");
        wr_reg(cspd_pkg::REG_DRIVE, 8'h10);
        u_pm.set_pins(1'b0, 1'b0, 1'b1);
        cyc(12);
        chk("hiz stop", 8'h00, pk(cpu[0]));
        chk("driven stop", 8'h0D, pk(cpu[1]));
        chk("free cpu", 8'h01, {7'h00, cpu[2].comp_oe});
        rd_chk(cspd_pkg::REG_STATUS, 8'h04, 8'h04, "halt flag");
        u_pm.set_pins(1'b0, 1'b1, 1'b1);
        cyc(8);
        chk("resumed", 8'h03, {6'h00, cpu[1].comp_oe, cpu[0].comp_oe});
        run_chk(8'h3F, 8'h03, 8'h00);
        wr_reg(cspd_pkg::REG_CPU_EN, 8'h0F);
    endtask : t_cpu

    task automatic t_pci();
        wr_reg(cspd_pkg::REG_EXP_EN, 8'h01);
        u_pm.set_pins(1'b0, 1'b1, 1'b0);
        cyc(10);
        run_chk(8'h00, 8'h02, 8'h00);
        chk("exp stop", 8'h0D, pk(exr[0]));
        chk("exp free", 8'h01, {7'h00, exr[1].comp_oe});
        rd_chk(cspd_pkg::REG_CTRL0, 8'hFF, 8'h00, "pin stop");
        u_pm.set_pins(1'b0, 1'b1, 1'b1);
        cyc(9);
        run_chk(8'h3F, 8'h03, 8'h00);
        wr_reg(cspd_pkg::REG_DRIVE, 8'h80);
        wr_reg(cspd_pkg::REG_CTRL0, 8'h00);
        cyc(6);
        run_chk(8'h00, 8'h02, 8'h00);
        chk("exp hiz stop", 8'h00, pk(exr[0]));
        rd_chk(cspd_pkg::REG_CTRL0, 8'hFF, 8'h00, "sw stop");
        wr_reg(cspd_pkg::REG_CTRL0, 8'hFF);
        cyc(6);
        rd_chk(cspd_pkg::REG_CTRL0, 8'hFF, 8'h08, "sw run");
    endtask : t_pci

    task automatic t_pd();
        wr_reg(cspd_pkg::REG_DRIVE, 8'h09);
        u_pm.set_pins(1'b1, 1'b1, 1'b1);
        u_pm.set_pins(1'b0, 1'b1, 1'b1);
        cyc(10);
        run_chk(8'h3F, 8'h03, 8'h00);
        u_pm.set_pins(1'b1, 1'b1, 1'b1);
        cyc(14);
        chk("pd hiz", 8'h00, pk(cpu[0]));
        chk("pd driven", 8'h0C, pk(cpu[1]));
        chk("pd exp hiz", 8'h00, pk(exr[7]));
        run_chk(8'h00, 8'h00, 8'h01);
        rd_chk(cspd_pkg::REG_STATUS, 8'h03, 8'h01, "down");
        u_pm.set_pins(1'b0, 1'b1, 1'b1);
        cyc(6);
        chk("pd release", 8'h0C, pk(cpu[0]));
        cyc(LOCK);
        run_chk(8'h3F, 8'h03, 8'h00);
    endtask : t_pd

    initial begin
        rst      = 1'b1;
        wr       = 1'b0;
        rd       = 1'b0;
        addr     = 4'h0;
        wdata    = 8'h00;
        failures = 0;
        n_checks = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_powerup();
        t_cpu();
        t_pci();
        t_pd();
        wrap_up();
    end

    initial begin
        repeat (5000) @(posedge clk);
        failures = failures + 1;
        wrap_up();
    end
endmodule : cspd_ctrl_tb
